//--- deser_pkg.sv
// Shared constants for the deserializer output control block
package deser_pkg;
  // Register map, byte addresses
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  // Control register fields
  localparam int CTRL_OE_BIT = 0;
  localparam int CTRL_PDN_BIT = 1;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_RESERVED_TIE_LOW_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h7;
  // Status register fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_PDN_BIT = 1;
  // Link framing
  localparam int LANES = 2;
  localparam int LANE_W = 16;
  localparam int WORD_W = 32;
  localparam logic [4:0] LANE_LAST_BIT = 5'h0F;
  localparam logic [4:0] RCLK_FALL_BIT = 5'h08;
  localparam logic [2:0] LOCK_FRAMES = 3'h4;
endpackage

//--- lane_word_if.sv
// Carrier between a lane deframer and the word assembly logic
`timescale 1ns/1ns
interface lane_word_if;
  logic [15:0] word;
  logic word_valid;
  logic frame_err;
  logic half_pulse;
  modport src (output word, output word_valid, output frame_err, output half_pulse);
  modport dst (input word, input word_valid, input frame_err, input half_pulse);
endinterface

//--- bit_sync.sv
// Two flop synchroniser for levels
`timescale 1ns/1ns
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // bit_sync

//--- lane_deframer.sv
// Frames one embedded-clock serial lane into 16-bit words
`timescale 1ns/1ns
module lane_deframer
  import deser_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic bit_i,
  lane_word_if.src out
);
  typedef enum logic [1:0] {
    HUNT = 2'b00,
    START = 2'b01,
    DATA = 2'b10,
    STOP = 2'b11
  } deframe_state_t;

  deframe_state_t state_r;
  logic [4:0] cnt_r;
  logic [15:0] shift_r;

  // Frame: start bit 1, 16 data bits msb first, stop bit 0
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= HUNT;
      cnt_r <= 5'h00;
      shift_r <= 16'h0000;
    end else if (clr_i) begin
      state_r <= HUNT;
      cnt_r <= 5'h00;
    end else begin
      unique case (state_r)
        HUNT: if (!bit_i) state_r <= START;
        START: begin
          cnt_r <= 5'h00;
          if (bit_i) state_r <= DATA;
        end
        DATA: begin
          shift_r <= {shift_r[14:0], bit_i};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == LANE_LAST_BIT) state_r <= STOP;
        end
        STOP: state_r <= bit_i ? HUNT : START;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out.word <= 16'h0000;
      out.word_valid <= 1'b0;
      out.frame_err <= 1'b0;
      out.half_pulse <= 1'b0;
    end else begin
      out.word_valid <= !clr_i && state_r == STOP && !bit_i;
      out.frame_err <= !clr_i && state_r == STOP && bit_i;
      out.half_pulse <= !clr_i && state_r == DATA && cnt_r == RCLK_FALL_BIT;
      if (state_r == STOP && !bit_i) out.word <= shift_r;
    end
  end
endmodule // lane_deframer

//--- deser_parallel_output_control.sv
// Deserializer output control: lock, recovered clock, parallel word, register slave
`timescale 1ns/1ns

// Operation
// - Unlocked: lock low, data and clock tristated
// - Locked: lock output driven high
// - Edge select picks rising or falling update
// - Output enable low tristates, lock keeps running
// - Power-down: standby, all outputs tristated
// - Recovered clock runs at word rate
// - Word delivered on 32-bit bus 31:0
module deser_parallel_output_control
  import deser_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic link_clk_i,
  input wire logic [LANES-1:0] serial_lane_in_i,
  output logic [WORD_W-1:0] parallel_data_out_o,
  output logic parallel_data_oe_n_o,
  output logic recovered_clock_out_o,
  output logic recovered_clock_oe_n_o,
  output logic lock_out_o,
  output logic lock_oe_n_o
);
  // System domain state
  logic [CTRL_W-1:0] ctrl_r;
  logic lock_sys_s;
  logic pdn_sys_s;
  logic [31:0] rdata_nxt;

  // Link domain state
  logic [1:0] link_rst_r;
  logic link_rst;
  logic [CTRL_W-1:0] ctrl_link_s;
  logic [CTRL_W-1:0] ctrl_prev_r;
  logic [CTRL_W-1:0] ctrl_link_r;
  logic [LANES-1:0] lane_s;
  logic out_en_s;
  logic pdn_s;
  logic edge_sel_s;
  logic link_clr;
  logic [2:0] lock_cnt_r;
  logic locked_r;
  logic locked_nxt;
  logic all_valid;
  logic any_err;
  logic lane_mismatch;
  logic [WORD_W-1:0] word_cat;
  logic [WORD_W-1:0] staged_r;
  logic rise_pt;
  logic fall_pt;
  logic [1:0] status_link;

  lane_word_if lane_bus [LANES] ();

  // Avalon-MM slave: one wait cycle, answer on the second edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Control register, only byte lane 0 carries fields
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == CTRL_OFS
                 && avs_byteenable_i[0]) begin
      ctrl_r <= avs_writedata_i[CTRL_W-1:0];
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (avs_address_i == CTRL_OFS) begin
      rdata_nxt[CTRL_W-1:0] = ctrl_r;
    end else if (avs_address_i == STATUS_OFS) begin
      rdata_nxt[STAT_LOCK_BIT] = lock_sys_s;
      rdata_nxt[STAT_PDN_BIT] = pdn_sys_s;
    end
  end

  // Unmapped addresses read zero, writes there are dropped
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // Link state seen by software
  assign status_link = {pdn_s, locked_r};

  bit_sync #(.W(2)) u_status_sync (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(status_link),
    .q_o({pdn_sys_s, lock_sys_s})
  );

  // Reset release synchronised to the link clock
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_rst_r <= 2'h3;
    end else begin
      link_rst_r <= {link_rst_r[0], 1'b0};
    end
  end

  assign link_rst = link_rst_r[1];

  // Control levels cross as quasi-static bits
  bit_sync #(.W(CTRL_W)) u_ctrl_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .d_i(ctrl_r),
    .q_o(ctrl_link_s)
  );

  bit_sync #(.W(LANES)) u_lane_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .d_i(serial_lane_in_i),
    .q_o(lane_s)
  );

  // Bits of one write may land a link cycle apart; take a value once it repeats
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      ctrl_prev_r <= '0;
      ctrl_link_r <= '0;
    end else begin
      ctrl_prev_r <= ctrl_link_s;
      if (ctrl_prev_r == ctrl_link_s) begin
        ctrl_link_r <= ctrl_link_s;
      end
    end
  end

  assign out_en_s = ctrl_link_r[CTRL_OE_BIT];
  assign pdn_s = ctrl_link_r[CTRL_PDN_BIT];
  assign edge_sel_s = ctrl_link_r[CTRL_EDGE_BIT];
  // Standby stops recovery and drops all framing
  assign link_clr = !pdn_s;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    lane_deframer u_deframer (
      .clk_i(link_clk_i),
      .rst_i(link_rst),
      .clr_i(link_clr),
      .bit_i(lane_s[g]),
      .out(lane_bus[g])
    );
  end

  // Lane 1 carries the upper half of the word
  assign word_cat = {lane_bus[1].word, lane_bus[0].word};
  assign all_valid = lane_bus[0].word_valid && lane_bus[1].word_valid;
  assign any_err = lane_bus[0].frame_err || lane_bus[1].frame_err;
  assign lane_mismatch = lane_bus[0].word_valid != lane_bus[1].word_valid;
  // Word end is the clock rise, mid word is the fall
  assign rise_pt = lane_bus[0].word_valid;
  assign fall_pt = lane_bus[0].half_pulse;

  // Lock needs consecutive aligned frames; any error drops it
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      lock_cnt_r <= 3'h0;
    end else if (link_clr || any_err || lane_mismatch) begin
      lock_cnt_r <= 3'h0;
    end else if (all_valid && lock_cnt_r != LOCK_FRAMES) begin
      lock_cnt_r <= lock_cnt_r + 3'h1;
    end
  end

  always_comb begin
    locked_nxt = locked_r;
    if (link_clr || any_err || lane_mismatch) begin
      locked_nxt = 1'b0;
    end else if (lock_cnt_r == LOCK_FRAMES) begin
      locked_nxt = 1'b1;
    end
  end

  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      locked_r <= 1'b0;
    end else begin
      locked_r <= locked_nxt;
    end
  end

  // Lock pin tracks the lock state; tristated only in standby
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      lock_out_o <= 1'b0;
      lock_oe_n_o <= 1'b1;
    end else begin
      lock_out_o <= locked_nxt && pdn_s;
      lock_oe_n_o <= !pdn_s;
    end
  end

  // Data and clock driven only when locked, enabled and powered
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      parallel_data_oe_n_o <= 1'b1;
      recovered_clock_oe_n_o <= 1'b1;
    end else begin
      parallel_data_oe_n_o <= !(locked_nxt && out_en_s && pdn_s);
      recovered_clock_oe_n_o <= !(locked_nxt && out_en_s && pdn_s);
    end
  end

  // Word rate clock rebuilt from lane 0 framing
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      recovered_clock_out_o <= 1'b0;
    end else if (rise_pt) begin
      recovered_clock_out_o <= 1'b1;
    end else if (fall_pt) begin
      recovered_clock_out_o <= 1'b0;
    end
  end

  // Holding the word lets the falling-edge mode present it half a word later
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      staged_r <= 32'h0000_0000;
    end else if (all_valid) begin
      staged_r <= word_cat;
    end
  end

  // Output word changes only with the selected clock edge
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      parallel_data_out_o <= 32'h0000_0000;
    end else if (rise_pt && edge_sel_s) begin
      parallel_data_out_o <= word_cat;
    end else if (fall_pt && !edge_sel_s) begin
      parallel_data_out_o <= staged_r;
    end
  end

  // Checks on the link side
  a_unlock_tristate: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    !lock_out_o |-> parallel_data_oe_n_o && recovered_clock_oe_n_o)
    else $error("data or clock driven while unlocked");

  a_lock_after_frames: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (pdn_s && lock_cnt_r == LOCK_FRAMES && !any_err && !lane_mismatch && !link_clr)
      |=> lock_out_o && !lock_oe_n_o)
    else $error("lock not raised after enough good frames");

  a_edge_select: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    $changed(parallel_data_out_o) |->
      ($past(edge_sel_s) ? $rose(recovered_clock_out_o) : $fell(recovered_clock_out_o)))
    else $error("data changed away from the selected clock edge");

  a_oe_tristate: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (!out_en_s && pdn_s && locked_r && !any_err && !lane_mismatch)
      |=> parallel_data_oe_n_o && recovered_clock_oe_n_o && lock_out_o)
    else $error("output disable did not tristate or lost lock");

  a_standby_outputs: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    !pdn_s |=> lock_oe_n_o && parallel_data_oe_n_o && recovered_clock_oe_n_o && !locked_r)
    else $error("standby left an output driven or lock held");

  a_clock_word_rate: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    rise_pt |=> recovered_clock_out_o ##1 (!fall_pt)[*8])
    else $error("recovered clock not tied to word boundary");

  a_word_layout: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (all_valid && edge_sel_s)
      |=> parallel_data_out_o == {$past(lane_bus[1].word), $past(lane_bus[0].word)})
    else $error("word lanes placed wrong on the bus");

  a_relock_wait: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    $rose(pdn_s) |-> (!lock_out_o && parallel_data_oe_n_o)[*8])
    else $error("lock reported too soon after power-down");

  a_error_unlocks: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    any_err |=> !locked_r ##1 !lock_out_o)
    else $error("frame error did not drop lock");

  a_lock_pin_driven: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    pdn_s |=> !lock_oe_n_o)
    else $error("lock pin released while powered");

  a_falling_word: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (fall_pt && !edge_sel_s) |=> parallel_data_out_o == $past(staged_r))
    else $error("falling edge mode did not present the held word");

  // Bus slave answers on the second edge of a request
  a_bus_answer: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one wait cycle");

  c_lock_gain: cover property (
    @(posedge link_clk_i) disable iff (link_rst)
    $rose(lock_out_o));

  c_falling_update: cover property (
    @(posedge link_clk_i) disable iff (link_rst)
    fall_pt && !edge_sel_s && locked_r);

  c_disable_locked: cover property (
    @(posedge link_clk_i) disable iff (link_rst)
    !out_en_s && lock_out_o);

  c_standby_locked: cover property (
    @(posedge link_clk_i) disable iff (link_rst)
    $fell(pdn_s) && locked_r);

  c_frame_error: cover property (
    @(posedge link_clk_i) disable iff (link_rst)
    any_err && locked_r);
endmodule // deser_parallel_output_control

//--- serializer_model.sv
// Companion serializer model driving the two embedded-clock lanes
`timescale 1ns/1ns
module serializer_model (
  input wire logic link_clk_i,
  output logic [1:0] lane_o
);
  // Entry is {force_bad_stop, word}
  logic [32:0] q[$];
  logic [32:0] cur;
  logic [31:0] last_w;
  logic busy;
  initial begin
    lane_o = 2'h0;
    last_w = 32'h0;
    busy = 1'b0;
    forever begin
      @(posedge link_clk_i);
      if (q.size() != 0) begin
        cur = q.pop_front();
        busy <= 1'b1;
        lane_o <= 2'h3;
        for (int i = 15; i >= 0; i--) begin
          @(posedge link_clk_i);
          lane_o <= {cur[16 + i], cur[i]};
        end
        @(posedge link_clk_i);
        // A high stop bit is the only fault the model makes on purpose
        lane_o <= {2{cur[32]}};
        if (!cur[32])
          last_w <= cur[31:0];
      end else begin
        busy <= 1'b0;
        lane_o <= 2'h0;
      end
    end
  end
endmodule // serializer_model

//--- deser_parallel_output_control_bench.sv
// Bench for the deserializer output control block
`timescale 1ns/1ns
module deser_parallel_output_control_bench
  import deser_pkg::*;
;
  logic sys_clk, rst, rd, wr, link_clk, rclk, rclk_oe_n, lock, lock_oe_n, wreq, d_oe_n;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata, rv, pdata;
  logic [1:0] lanes;
  int n_fail, tests_run;

  serializer_model p (.link_clk_i(link_clk), .lane_o(lanes));

  deser_parallel_output_control i_dut (.sys_clk_i(sys_clk), .rst_i(rst),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .link_clk_i(link_clk), .serial_lane_in_i(lanes), .parallel_data_out_o(pdata),
    .parallel_data_oe_n_o(d_oe_n), .recovered_clock_out_o(rclk),
    .recovered_clock_oe_n_o(rclk_oe_n), .lock_out_o(lock), .lock_oe_n_o(lock_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Odd offset keeps the link clock out of phase with the system clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Writes keep the reserved bit low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    // Waitrequest is sampled at the rising edge, before the slave updates it
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100)
      chk("bus answer", 32'h0, 32'h1);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(what, exp, rv);
  endtask

  task automatic lw(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((p.q.size() != 0 || p.busy !== 1'b0) && n < 3000) begin
      @(negedge link_clk);
      n++;
    end
    lw(6);
  endtask

  task automatic pins(input logic lk, input logic oe_n, input logic lk_oe_n);
    chk("lock", {31'h0, lk}, {31'h0, lock});
    chk("data oe_n", {31'h0, oe_n}, {31'h0, d_oe_n});
    chk("clock oe_n", {31'h0, oe_n}, {31'h0, rclk_oe_n});
    chk("lock oe_n", {31'h0, lk_oe_n}, {31'h0, lock_oe_n});
  endtask

  // Lock must come with the fourth clean frame and not before
  task automatic relock();
    int n;
    n = 0;
    for (int i = 0; i < 4; i++)
      p.q.push_back({1'b0, 32'h1234_5678 + 32'(i)});
    while (p.q.size() != 0 && n < 3000) begin
      @(negedge link_clk);
      n++;
    end
    chk("lock early", 32'h0, {31'h0, lock});
    drain();
    pins(1'b1, 1'b0, 1'b0);
  endtask

  // Check the word at the selected clock edge and that it holds across the other
  task automatic edges(input logic rise, input int n);
    logic [31:0] hold;
    time t0;
    t0 = 0;
    for (int i = 0; i < n; i++) begin
      if (rise)
        @(posedge rclk);
      else
        @(negedge rclk);
      if (rise && i > 0)
        chk("clock period", 32'd864, 32'($time - t0));
      t0 = $time;
      #1;
      chk("word", p.last_w, pdata);
      hold = pdata;
      if (rise)
        @(negedge rclk);
      else
        @(posedge rclk);
      #1;
      chk("word held", hold, pdata);
    end
  endtask

  task automatic stream(input logic rise);
    for (int i = 0; i < 4; i++)
      p.q.push_back({1'b0, 32'hA5C3_1E96 ^ (32'h0F0F_3355 * 32'(i + 1))});
    edges(rise, 3);
    drain();
  endtask

  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    be = 4'hF;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    lw(8);
    rd_chk("ctrl reset", CTRL_OFS, 32'h0000_0007);
    rd_chk("status reset", STATUS_OFS, 32'h0000_0002);
    rd_chk("unmapped", 4'h8, 32'h0000_0000);
    pins(1'b0, 1'b1, 1'b0);
    relock();
    rd_chk("status locked", STATUS_OFS, 32'h0000_0003);
    stream(1'b1);
    bus(1'b1, CTRL_OFS, 32'h0000_0003, 4'hF);
    lw(8);
    stream(1'b0);
    bus(1'b1, CTRL_OFS, 32'h0000_0006, 4'hF);
    lw(8);
    pins(1'b1, 1'b1, 1'b0);
    rd_chk("status disabled", STATUS_OFS, 32'h0000_0003);
    bus(1'b1, CTRL_OFS, 32'h0000_0000, 4'h0);
    rd_chk("ctrl masked write", CTRL_OFS, 32'h0000_0006);
    bus(1'b1, CTRL_OFS, 32'h0000_0005, 4'hF);
    lw(8);
    pins(1'b0, 1'b1, 1'b1);
    rd_chk("status standby", STATUS_OFS, 32'h0000_0000);
    bus(1'b1, CTRL_OFS, 32'h0000_0007, 4'hF);
    lw(8);
    pins(1'b0, 1'b1, 1'b0);
    relock();
    p.q.push_back({1'b1, 32'hFFFF_0000});
    drain();
    pins(1'b0, 1'b1, 1'b0);
    relock();
    end_of_test();
  end

  // Whole run needs well under 100 us
  initial begin
    #300000;
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    end_of_test();
  end
endmodule // deser_parallel_output_control_bench
